// >>> include/rfp_pkg.sv
package rfp_pkg;
   // clock and link bit rates
   localparam int unsigned CLK_HZ         = 200_000_000;
   localparam int unsigned RATE_LO_BPS    = 212_000;
   localparam int unsigned RATE_HI_BPS    = 424_000;
   localparam int unsigned MIN_HALF_CYC   = 4;
   localparam int unsigned MAX_HALF_CYC   = 1023;
   // frame layout
   localparam logic [7:0]  PREAMBLE_BYTES = 8'h06;
   localparam logic [15:0] SYNC_WORD      = 16'hb24d;
   localparam logic [7:0]  SIZE_EXTRA     = 8'h01;
   localparam logic [7:0]  CRC_BYTES      = 8'h02;
   localparam logic [15:0] CRC_POLY       = 16'h1021;
   localparam logic [15:0] CRC_INIT       = 16'h0000;
   localparam logic [7:0]  MAX_TX_COUNT   = 8'hfe;
   // memory organisation
   localparam int unsigned BLOCK_BYTES    = 16;
   localparam int unsigned MEM_BLOCKS     = 32;
   localparam logic [15:0] LAST_ADDR      = 16'h01ff;
   // register port map
   localparam int unsigned ADDR_W         = 7;
   localparam logic [6:0]  REG_CTRL       = 7'h00;
   localparam logic [6:0]  REG_STATUS     = 7'h01;
   localparam logic [6:0]  REG_CFG_FLAG   = 7'h02;
   localparam logic [6:0]  REG_CFG_CHECK  = 7'h03;
   localparam logic [6:0]  REG_RF_RO      = 7'h04;
   localparam logic [6:0]  REG_SER_RO     = 7'h05;
   localparam logic [6:0]  REG_PROT       = 7'h06;
   localparam logic [6:0]  REG_STORE_BASE = 7'h20;
   localparam logic [6:0]  REG_ACT_BASE   = 7'h40;
   localparam int unsigned CTRL_RATE_BIT  = 0;
   localparam int unsigned ST_POWER_BIT   = 0;
   localparam int unsigned ST_RX_BIT      = 1;
   localparam int unsigned ST_TX_BIT      = 2;
   localparam int unsigned ST_RESP_BIT    = 3;
   localparam int unsigned ST_CFG_BIT     = 4;
   // configuration validity codes
   localparam logic [7:0]  CFG_ON         = 8'h01;
   localparam logic [7:0]  CFG_CHECK_OK   = 8'hfe;
   // deferred parameter bytes, index 17 first
   localparam int unsigned PARAM_BYTES    = 18;
   localparam logic [6:0]  PARAM_BYTES_A  = 7'h12;
   typedef logic [PARAM_BYTES-1:0][7:0] rfp_params_t;
   localparam rfp_params_t DEF_DEFERRED = {
      8'he0, 8'h00, 8'hff, 8'hff,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hfe, 8'h02,
      8'hff, 8'haa, 8'hc0, 8'h47, 8'h54, 8'h00};
   localparam logic [7:0]  DEF_RF_RO      = 8'h00;
   localparam logic [7:0]  DEF_SER_RO     = 8'h00;
   localparam logic [7:0]  DEF_PROT       = 8'h00;

   typedef enum logic [2:0] {
      RX_HUNT = 3'b000,
      RX_SIZE = 3'b001,
      RX_DATA = 3'b010,
      RX_CRC  = 3'b011
   } rfp_rx_e;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_PRE  = 3'b001,
      TX_SYNC = 3'b010,
      TX_SIZE = 3'b011,
      TX_DATA = 3'b100,
      TX_CRC  = 3'b101
   } rfp_tx_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              wr;
      logic              rd;
   } rfp_bus_s;

   function automatic logic [31:0] rfp_manch16(input logic [15:0] w);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 16; i++) begin
         m[2*i +: 2] = w[i] ? 2'b10 : 2'b01;
      end
      return m;
   endfunction : rfp_manch16

   localparam logic [31:0] SYNC_MANCH = rfp_manch16(SYNC_WORD);

   function automatic logic [15:0] rfp_crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] x;
      x = c;
      for (int i = 7; i >= 0; i--) begin
         x = (x[15] ^ b[i]) ? ({x[14:0], 1'b0} ^ CRC_POLY) : {x[14:0], 1'b0};
      end
      return x;
   endfunction : rfp_crc_byte
endpackage : rfp_pkg

// >>> design/rfp_frame_apply.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Without a valid enable flag and check code every parameter takes its default.
// - Read-only controls and protection setting follow a rewrite at once while enabled.
// - All other system parameters change only at the next power-up after a rewrite.
// - Loss of RF-derived supply is power-off and its return is the power-up that loads them.
// - Protocol addresses equal physical ones; block k spans bytes 16k to 16k+15.
// - A response is sent only after a received command has been fully handled.
// - Both directions use Manchester bit coding.
// - Characters are eight bits, MSB first, with no framing bits and no gaps.
// - A frame opens with six zero bytes and the two-byte sync pattern for alignment.
// - A size byte holding data count plus one precedes the data bytes.
// - The data field is a command from the reader and a response from the tag.
// - A frame ends with a CRC-16, polynomial 0x1021, initial value zero.
////////////////////////////////////////////////////////////////////////////////
module rfp_frame_apply #(
   parameter int unsigned CLK_HZ = rfp_pkg::CLK_HZ
) (
   input  wire logic                 clock_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 ce_in,
   input  wire rfp_pkg::rfp_bus_s    bus_in,
   output logic [7:0]                rd_data_out,
   input  wire logic                 rf_power_ok_in,
   input  wire logic                 rf_rx_in,
   output logic                      tx_mod_out,
   input  wire logic                 tx_start_in,
   input  wire logic [7:0]           tx_count_in,
   input  wire logic [7:0]           tx_byte_in,
   output logic                      tx_next_out,
   output logic                      tx_busy_out,
   output logic [7:0]                rx_byte_out,
   output logic                      rx_byte_valid_out,
   output logic                      rx_frame_ok_out,
   output logic                      rx_frame_bad_out,
   output logic                      resp_pending_out,
   output logic [7:0]                rf_ro_out,
   output logic [7:0]                ser_ro_out,
   output logic [7:0]                prot_out,
   output rfp_pkg::rfp_params_t      active_params_out,
   input  wire logic [15:0]          map_addr_in,
   output logic [8:0]                map_phys_out,
   output logic [4:0]                map_block_out,
   output logic [3:0]                map_byte_out,
   output logic                      map_range_err_out
);
   import rfp_pkg::*;

   localparam int unsigned HALF_LO_CYC = CLK_HZ / (2 * RATE_LO_BPS);
   localparam int unsigned HALF_HI_CYC = CLK_HZ / (2 * RATE_HI_BPS);

   if (HALF_HI_CYC < MIN_HALF_CYC || HALF_LO_CYC > MAX_HALF_CYC) begin : g_bad_clock
      $error("clock rate cannot serve the bit timing");
   end

   typedef struct packed {
      logic [2:0]  sync_rx;
      logic [2:0]  sync_pw;
      logic        rx_lvl;
      logic        pw_lvl;
      logic        rate_hi;
      logic [7:0]  cfg_flag;
      logic [7:0]  cfg_check;
      logic [7:0]  st_rf_ro;
      logic [7:0]  st_ser_ro;
      logic [7:0]  st_prot;
      rfp_params_t store;
      rfp_params_t active;
      logic [7:0]  rf_ro;
      logic [7:0]  ser_ro;
      logic [7:0]  prot;
      logic [7:0]  rd_data;
      rfp_rx_e     rx_st;
      logic [9:0]  rx_h;
      logic [31:0] hs;
      logic        rx_phase;
      logic [7:0]  rx_sh;
      logic [2:0]  rx_bits;
      logic [7:0]  rx_rem;
      logic [15:0] rx_crc;
      logic [7:0]  rx_byte;
      logic        rx_valid;
      logic        rx_ok;
      logic        rx_bad;
      logic        resp_pending;
      rfp_tx_e     tx_st;
      logic [9:0]  tx_h;
      logic [3:0]  tx_half;
      logic [7:0]  tx_cur;
      logic [7:0]  tx_cnt;
      logic [7:0]  tx_count;
      logic [15:0] tx_crc;
      logic        tx_mod;
      logic        tx_next;
      logic        tx_busy;
      logic [8:0]  map_phys;
      logic [4:0]  map_block;
      logic [3:0]  map_byte;
      logic        map_err;
   } rfp_state_s;

   localparam rfp_state_s RST_STATE = '{
      store: DEF_DEFERRED, active: DEF_DEFERRED, rf_ro: DEF_RF_RO, ser_ro: DEF_SER_RO,
      prot: DEF_PROT, rx_st: RX_HUNT, tx_st: TX_IDLE, default: '0};

   rfp_state_s  r;
   rfp_state_s  n;
   logic [9:0]  half;
   logic        cfg_valid;
   logic        cfg_touch;
   logic        pw_rise;
   logic        rx_sample;
   logic        rx_byte_end;
   logic [7:0]  rx_byte;
   logic [15:0] rx_crc_new;
   logic [6:0]  sidx;
   logic [6:0]  aidx;

   assign half      = r.rate_hi ? 10'(HALF_HI_CYC) : 10'(HALF_LO_CYC);
   assign cfg_valid = (r.cfg_flag == CFG_ON) && (r.cfg_check == CFG_CHECK_OK);
   assign cfg_touch = bus_in.wr &&
                      (bus_in.addr == REG_CFG_FLAG || bus_in.addr == REG_CFG_CHECK);
   // only second and third stages are compared; first stage may be metastable
   assign pw_rise   = (r.sync_pw[1] == r.sync_pw[2]) && r.sync_pw[2] && !r.pw_lvl;
   assign sidx      = bus_in.addr - REG_STORE_BASE;
   assign aidx      = bus_in.addr - REG_ACT_BASE;

   always_comb begin : comb
      n             = r;
      n.rx_valid    = 1'b0;
      n.rx_ok       = 1'b0;
      n.rx_bad      = 1'b0;
      n.tx_next     = 1'b0;
      n.rd_data     = 8'h00;
      rx_sample     = 1'b0;
      rx_byte_end   = 1'b0;
      rx_byte       = {r.rx_sh[6:0], r.hs[0]};
      rx_crc_new    = rfp_crc_byte(r.rx_crc, rx_byte);
      n.sync_rx     = {r.sync_rx[1:0], rf_rx_in};
      n.sync_pw     = {r.sync_pw[1:0], rf_power_ok_in};
      if (r.sync_rx[1] == r.sync_rx[2]) begin
         n.rx_lvl = r.sync_rx[2];
      end
      if (r.sync_pw[1] == r.sync_pw[2]) begin
         n.pw_lvl = r.sync_pw[2];
      end
      ////////////////////////////////////////////////////////////////////////
      if (bus_in.wr) begin
         case (bus_in.addr)
            REG_CTRL:      n.rate_hi = bus_in.wdata[CTRL_RATE_BIT];
            REG_CFG_FLAG:  n.cfg_flag = bus_in.wdata;
            REG_CFG_CHECK: n.cfg_check = bus_in.wdata;
            REG_RF_RO:     n.st_rf_ro = bus_in.wdata;
            REG_SER_RO:    n.st_ser_ro = bus_in.wdata;
            REG_PROT:      n.st_prot = bus_in.wdata;
            default: begin
               if (sidx < PARAM_BYTES_A) begin
                  n.store[sidx[4:0]] = bus_in.wdata;
               end
            end
         endcase
      end
      if (bus_in.rd) begin
         case (bus_in.addr)
            REG_CTRL:      n.rd_data = {7'h00, r.rate_hi};
            REG_STATUS:    n.rd_data = {3'h0, cfg_valid, r.resp_pending,
                                        r.tx_st != TX_IDLE, r.rx_st != RX_HUNT, r.pw_lvl};
            REG_CFG_FLAG:  n.rd_data = r.cfg_flag;
            REG_CFG_CHECK: n.rd_data = r.cfg_check;
            REG_RF_RO:     n.rd_data = r.st_rf_ro;
            REG_SER_RO:    n.rd_data = r.st_ser_ro;
            REG_PROT:      n.rd_data = r.st_prot;
            default: begin
               if (sidx < PARAM_BYTES_A) begin
                  n.rd_data = r.store[sidx[4:0]];
               end else if (aidx < PARAM_BYTES_A) begin
                  n.rd_data = r.active[aidx[4:0]];
               end
            end
         endcase
      end
      ////////////////////////////////////////////////////////////////////////
      n.rf_ro  = cfg_valid ? r.st_rf_ro : DEF_RF_RO;
      n.ser_ro = cfg_valid ? r.st_ser_ro : DEF_SER_RO;
      n.prot   = cfg_valid ? r.st_prot : DEF_PROT;
      if (pw_rise) begin
         n.active = cfg_valid ? r.store : DEF_DEFERRED;
      end
      n.map_phys  = map_addr_in[8:0];
      n.map_block = map_addr_in[8:4];
      n.map_byte  = map_addr_in[3:0];
      n.map_err   = map_addr_in > LAST_ADDR;
      ////////////////////////////////////////////////////////////////////////
      // receive: half-bit sampler re-centred on every line edge
      if (n.rx_lvl != r.rx_lvl) begin
         n.rx_h = {1'b0, half[9:1]};
      end else if (r.rx_h == 10'h000) begin
         n.rx_h    = half - 10'd1;
         rx_sample = 1'b1;
      end else begin
         n.rx_h = r.rx_h - 10'd1;
      end
      // half duplex: own transmission is not received
      if (rx_sample && r.tx_st == TX_IDLE) begin
         n.hs       = {r.hs[30:0], r.rx_lvl};
         n.rx_phase = ~r.rx_phase;
         if (r.rx_st == RX_HUNT) begin
            if ({r.hs[30:0], r.rx_lvl} == SYNC_MANCH) begin
               n.rx_st    = RX_SIZE;
               n.rx_phase = 1'b0;
               n.rx_bits  = 3'h0;
               n.rx_crc   = CRC_INIT;
            end
         end else if (r.rx_phase) begin
            if (r.hs[0] == r.rx_lvl) begin
               n.rx_st = RX_HUNT;
            end else begin
               n.rx_sh   = rx_byte;
               n.rx_bits = r.rx_bits + 3'd1;
               if (r.rx_bits == 3'd7) begin
                  rx_byte_end = 1'b1;
                  n.rx_crc    = rx_crc_new;
                  case (r.rx_st)
                     RX_SIZE: begin
                        n.rx_rem = (rx_byte == SIZE_EXTRA) ? CRC_BYTES :
                                   rx_byte - SIZE_EXTRA;
                        n.rx_st  = (rx_byte == 8'h00) ? RX_HUNT :
                                   (rx_byte == SIZE_EXTRA) ? RX_CRC : RX_DATA;
                     end
                     RX_DATA: begin
                        n.rx_byte  = rx_byte;
                        n.rx_valid = 1'b1;
                        n.rx_rem   = (r.rx_rem == 8'h01) ? CRC_BYTES : r.rx_rem - 8'h01;
                        n.rx_st    = (r.rx_rem == 8'h01) ? RX_CRC : RX_DATA;
                     end
                     RX_CRC: begin
                        n.rx_rem = r.rx_rem - 8'h01;
                        if (r.rx_rem == 8'h01) begin
                           n.rx_st = RX_HUNT;
                           // residue over size, data and crc is zero for a good frame
                           n.rx_ok        = rx_crc_new == 16'h0000;
                           n.rx_bad       = rx_crc_new != 16'h0000;
                           n.resp_pending = r.resp_pending || rx_crc_new == 16'h0000;
                        end
                     end
                     default: n.rx_st = RX_HUNT;
                  endcase
               end
            end
         end
      end
      ////////////////////////////////////////////////////////////////////////
      // transmit: one byte is sixteen half-bits, next byte loaded without a gap
      case (r.tx_st)
         TX_IDLE: begin
            if (tx_start_in && r.resp_pending && tx_count_in <= MAX_TX_COUNT) begin
               // a command completing in this very cycle keeps its response armed
               n.resp_pending = n.rx_ok;
               n.tx_st        = TX_PRE;
               n.tx_cnt       = PREAMBLE_BYTES - 8'h01;
               n.tx_cur       = 8'h00;
               n.tx_half      = 4'h0;
               n.tx_h         = half - 10'd1;
               n.tx_count     = tx_count_in;
               n.tx_crc       = CRC_INIT;
            end
         end
         default: begin
            if (r.tx_h != 10'h000) begin
               n.tx_h = r.tx_h - 10'd1;
            end else begin
               n.tx_h    = half - 10'd1;
               n.tx_half = r.tx_half + 4'd1;
               if (r.tx_half == 4'hf) begin
                  case (r.tx_st)
                     TX_PRE: begin
                        n.tx_st  = (r.tx_cnt == 8'h00) ? TX_SYNC : TX_PRE;
                        n.tx_cur = (r.tx_cnt == 8'h00) ? SYNC_WORD[15:8] : 8'h00;
                        n.tx_cnt = (r.tx_cnt == 8'h00) ? 8'h01 : r.tx_cnt - 8'h01;
                     end
                     TX_SYNC: begin
                        if (r.tx_cnt == 8'h00) begin
                           n.tx_st  = TX_SIZE;
                           n.tx_cur = r.tx_count + SIZE_EXTRA;
                           n.tx_crc = rfp_crc_byte(r.tx_crc, r.tx_count + SIZE_EXTRA);
                        end else begin
                           n.tx_cur = SYNC_WORD[7:0];
                           n.tx_cnt = 8'h00;
                        end
                     end
                     TX_SIZE, TX_DATA: begin
                        if ((r.tx_st == TX_SIZE ? r.tx_count : r.tx_cnt) == 8'h00) begin
                           n.tx_st  = TX_CRC;
                           n.tx_cur = r.tx_crc[15:8];
                           n.tx_cnt = 8'h01;
                        end else begin
                           n.tx_st   = TX_DATA;
                           n.tx_cur  = tx_byte_in;
                           n.tx_next = 1'b1;
                           n.tx_crc  = rfp_crc_byte(r.tx_crc, tx_byte_in);
                           n.tx_cnt  = (r.tx_st == TX_SIZE ? r.tx_count : r.tx_cnt) - 8'h01;
                        end
                     end
                     default: begin
                        n.tx_st  = (r.tx_cnt == 8'h01) ? TX_CRC : TX_IDLE;
                        n.tx_cur = r.tx_crc[7:0];
                        n.tx_cnt = 8'h00;
                     end
                  endcase
               end
            end
         end
      endcase
      // first half carries the bit, second half its complement
      n.tx_mod = (n.tx_st == TX_IDLE) ? 1'b0 :
                 n.tx_cur[3'd7 - n.tx_half[3:1]] ^ n.tx_half[0];
      if (!r.pw_lvl) begin
         n.rx_st        = RX_HUNT;
         n.tx_st        = TX_IDLE;
         n.tx_mod       = 1'b0;
         n.resp_pending = 1'b0;
      end
      n.tx_busy = n.tx_st != TX_IDLE;
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin : regs
      if (!rst_n_in) begin
         r <= RST_STATE;
      end else if (ce_in) begin
         r <= n;
      end
   end

   assign rd_data_out       = r.rd_data;
   assign tx_mod_out        = r.tx_mod;
   assign tx_next_out       = r.tx_next;
   assign tx_busy_out       = r.tx_busy;
   assign rx_byte_out       = r.rx_byte;
   assign rx_byte_valid_out = r.rx_valid;
   assign rx_frame_ok_out   = r.rx_ok;
   assign rx_frame_bad_out  = r.rx_bad;
   assign resp_pending_out  = r.resp_pending;
   assign rf_ro_out         = r.rf_ro;
   assign ser_ro_out        = r.ser_ro;
   assign prot_out          = r.prot;
   assign active_params_out = r.active;
   assign map_phys_out      = r.map_phys;
   assign map_block_out     = r.map_block;
   assign map_byte_out      = r.map_byte;
   assign map_range_err_out = r.map_err;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_ro_write;
      ce_in && bus_in.wr && bus_in.addr == REG_RF_RO && cfg_valid && !cfg_touch;
   endsequence
   sequence s_ro_apply;
      ce_in && cfg_valid;
   endsequence

   AST_DEFAULT_IMM: assert property (ce_in && !cfg_valid |=> rf_ro_out == DEF_RF_RO
      && ser_ro_out == DEF_SER_RO && prot_out == DEF_PROT)
      else $error("defaults not applied without valid configuration");
   AST_IMMEDIATE: assert property (s_ro_write ##1 s_ro_apply
      |=> rf_ro_out == $past(bus_in.wdata, 2))
      else $error("read-only control rewrite not applied at once");
   AST_DEFERRED: assert property ($changed(active_params_out) |-> $past(pw_rise && ce_in))
      else $error("deferred parameters changed outside power-up");
   AST_POWER_LOAD: assert property (ce_in && pw_rise && cfg_valid
      |=> active_params_out == $past(r.store))
      else $error("power-up did not load stored parameters");
   AST_MAP: assert property (ce_in |=> map_block_out == $past(map_addr_in[8:4])
      && map_phys_out == $past(map_addr_in[8:0]))
      else $error("address mapping wrong");
   AST_NO_UNSOLICITED: assert property ($rose(tx_busy_out) |-> $past(r.resp_pending)
      && (!resp_pending_out || rx_frame_ok_out))
      else $error("response started without a received command");
   AST_MANCH_TX: assert property (tx_busy_out && r.tx_half[0] && $past(tx_busy_out)
      && !$past(r.tx_half[0]) |-> tx_mod_out != $past(tx_mod_out))
      else $error("second half-bit not inverted");
   AST_RATE: assert property (ce_in && tx_busy_out && r.tx_h == 10'h000 && r.pw_lvl
      ##1 tx_busy_out |-> r.tx_h == 10'($past(half) - 10'd1))
      else $error("half-bit period does not match selected rate");
   AST_SYNC: assert property (r.rx_st == RX_SIZE && $past(r.rx_st) == RX_HUNT
      |-> r.hs == SYNC_MANCH)
      else $error("alignment taken without sync pattern");
   AST_SIZE_ZERO: assert property (ce_in && rx_byte_end && r.rx_st == RX_SIZE
      && rx_byte == 8'h00 |=> r.rx_st == RX_HUNT)
      else $error("zero size byte accepted");
   AST_CRC_GATE: assert property ($rose(resp_pending_out) |-> rx_frame_ok_out && !rx_frame_bad_out)
      else $error("response armed without good crc");
endmodule : rfp_frame_apply
`default_nettype wire

// >>> bench/rfp_reader_model.sv
`timescale 1ns/1ps
`default_nettype none
module rfp_reader_model (
   input  wire logic clock_in,
   input  wire logic tx_mod_in,
   output logic      rx_line_out
);
   int         half = 10;
   logic [7:0] got[$];
   initial rx_line_out = 1'b0;
   function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0);
      return c;
   endfunction : crc
   // line rests low between frames, as a silent field would
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         repeat (half) @(posedge clock_in) rx_line_out <= b[i];
         repeat (half) @(posedge clock_in) rx_line_out <= ~b[i];
      end
   endtask : send
   task automatic frame(input logic [7:0] d[$], input logic [15:0] flip);
      logic [15:0] c;
      c = crc(16'h0, 8'(d.size() + 1));
      foreach (d[i]) c = crc(c, d[i]);
      c = c ^ flip;
      repeat (6) send(8'h00);
      send(8'hb2);
      send(8'h4d);
      send(8'(d.size() + 1));
      foreach (d[i]) send(d[i]);
      send(c[15:8]);
      send(c[7:0]);
      @(posedge clock_in) rx_line_out <= 1'b0;
   endtask : frame
   // samples the first half of each bit; one is a high first half
   task automatic recv(input int n);
      logic [7:0] b;
      got.delete();
      repeat (half / 2) @(posedge clock_in);
      repeat (n) begin
         for (int i = 7; i >= 0; i--) begin
            b[i] = tx_mod_in;
            repeat (2 * half) @(posedge clock_in);
         end
         got.push_back(b);
      end
   endtask : recv
endmodule : rfp_reader_model
`default_nettype wire

// >>> bench/test_rfp_frame_apply.sv
`timescale 1ns/1ps
`default_nettype none
module test_rfp_frame_apply;
   import rfp_pkg::*;
   logic        clock_in, rst_n_in, ce_in, rf_power_ok_in, rf_rx_in, tx_mod_out, tx_start_in;
   logic        tx_next_out, tx_busy_out, rx_byte_valid_out, rx_frame_ok_out, rx_frame_bad_out;
   logic        resp_pending_out, map_range_err_out;
   rfp_bus_s    bus_in;
   logic [7:0]  rd_data_out, tx_count_in, tx_byte_in, rx_byte_out, rf_ro_out, ser_ro_out, prot_out;
   rfp_params_t active_params_out;
   logic [15:0] map_addr_in, c;
   logic [8:0]  map_phys_out;
   logic [4:0]  map_block_out;
   logic [3:0]  map_byte_out;
   logic [7:0]  rxq[$], e[$];
   int          n_errors = 0, total_checks = 0, n_ok = 0, n_bad = 0, n_next = 0;
   // address, physical, block, byte, range error
   logic [34:0] rows[3] = '{{16'h000f, 9'h00f, 5'h00, 4'hf, 1'b0},
      {16'h0010, 9'h010, 5'h01, 4'h0, 1'b0}, {16'h01ff, 9'h1ff, 5'h1f, 4'hf, 1'b0}};
   // slow clock figure gives ten cycles a half-bit at the low rate and five at the high, keeping frames short
   rfp_frame_apply #(.CLK_HZ(4_240_000)) rfp_frame_apply_inst (.*);
   rfp_reader_model rfp_reader_model_inst (.clock_in(clock_in), .tx_mod_in(tx_mod_out),
      .rx_line_out(rf_rx_in));
   task automatic check(input logic [143:0] g, input logic [143:0] x);
      total_checks++;
      if (g !== x) begin
         n_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, g, x);
      end
   endtask : check
   task automatic results();
      $display("checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results
   task automatic give_up(input logic stuck);
      if (stuck) begin
         n_errors++;
         results();
      end
   endtask : give_up
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clock_in) bus_in <= '{a, d, 1'b1, 1'b0};
      @(posedge clock_in) bus_in <= '0;
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] x);
      @(posedge clock_in) bus_in <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock_in) bus_in <= '0;
      #1 check(rd_data_out, x);
   endtask : rd
   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      if (rx_byte_valid_out === 1'b1) rxq.push_back(rx_byte_out);
      n_ok += int'(rx_frame_ok_out === 1'b1);
      n_bad += int'(rx_frame_bad_out === 1'b1);
      n_next += int'(tx_next_out === 1'b1);
   end
   initial begin
      {rst_n_in, rf_power_ok_in, tx_start_in, tx_count_in, tx_byte_in, map_addr_in} = '0;
      ce_in = 1'b1;
      bus_in = '0;
      repeat (4) @(posedge clock_in);
      check(active_params_out, DEF_DEFERRED);
      rst_n_in <= 1'b1;
      foreach (rows[i]) begin
         @(posedge clock_in) map_addr_in <= rows[i][34:19];
         @(posedge clock_in) #1;
         check({map_phys_out, map_block_out, map_byte_out, map_range_err_out}, rows[i][18:0]);
      end
      @(posedge clock_in) map_addr_in <= 16'h0200;
      rf_power_ok_in <= 1'b1;
      repeat (10) @(posedge clock_in);
      check(map_range_err_out, 1'b1);
      wr(REG_RF_RO, 8'h5a);
      repeat (2) @(posedge clock_in);
      check(rf_ro_out, DEF_RF_RO);
      wr(REG_CFG_FLAG, CFG_ON);
      wr(REG_CFG_CHECK, CFG_CHECK_OK);
      wr(REG_RF_RO, 8'h3c);
      wr(REG_SER_RO, 8'h69);
      wr(REG_PROT, 8'h81);
      wr(REG_STORE_BASE, 8'h77);
      check({rf_ro_out, ser_ro_out, prot_out}, 24'h3c6981);
      rd(REG_STATUS, 8'h11);
      rd(REG_ACT_BASE, DEF_DEFERRED[0]);
      rd(7'h7f, 8'h00);
      @(posedge clock_in) rf_power_ok_in <= 1'b0;
      repeat (10) @(posedge clock_in);
      rf_power_ok_in <= 1'b1;
      repeat (10) @(posedge clock_in);
      check(active_params_out[0], 8'h77);
      tx_start_in <= 1'b1;
      @(posedge clock_in) tx_start_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      check(tx_busy_out, 1'b0);
      rfp_reader_model_inst.frame('{8'h11}, 16'h0001);
      for (int k = 0; k < 400 && n_bad == 0; k++) @(posedge clock_in);
      give_up(n_bad == 0);
      check(resp_pending_out, 1'b0);
      for (int r = 0; r < 2; r++) begin
         wr(REG_CTRL, 8'(r));
         rfp_reader_model_inst.half = r ? 5 : 10;
         rxq.delete();
         rfp_reader_model_inst.frame('{8'ha5, 8'h3c}, 16'h0000);
         for (int k = 0; k < 400 && n_ok == r; k++) @(posedge clock_in);
         give_up(n_ok == r);
         check({rxq.size(), rxq[0], rxq[1]}, {32'h2, 16'ha53c});
         check(resp_pending_out, 1'b1);
         tx_count_in <= 8'h01;
         tx_byte_in <= 8'hc3;
         tx_start_in <= 1'b1;
         @(posedge clock_in) tx_start_in <= 1'b0;
         for (int k = 0; k < 50 && tx_busy_out !== 1'b1; k++) @(negedge clock_in);
         give_up(tx_busy_out !== 1'b1);
         rfp_reader_model_inst.recv(12);
         c = rfp_reader_model_inst.crc(rfp_reader_model_inst.crc(16'h0, 8'h02), 8'hc3);
         e = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
               8'hb2, 8'h4d, 8'h02, 8'hc3, c[15:8], c[7:0]};
         foreach (e[i]) check(rfp_reader_model_inst.got[i], e[i]);
         check(resp_pending_out, 1'b0);
         check(n_next, r + 1);
         for (int k = 0; k < 400 && tx_busy_out !== 1'b0; k++) @(posedge clock_in);
         give_up(tx_busy_out !== 1'b0);
      end
      results();
   end
endmodule : test_rfp_frame_apply
`default_nettype wire
